// File: inc/cond_flow_pkg.sv
// Shared codes and constants for the conditional skip and branch unit.
// Assumes one core clock; the decoder presents one decoded operation at a time.
package cond_flow_pkg;

    localparam int PC_W   = 16;
    localparam int OFF_W  = 7;
    localparam int DATA_W = 8;
    localparam int BIT_W  = 3;
    localparam int CNT_W  = 2;

    // Bit positions inside the status flags byte
    localparam logic [BIT_W-1:0] FLAG_C = 3'h0;
    localparam logic [BIT_W-1:0] FLAG_Z = 3'h1;
    localparam logic [BIT_W-1:0] FLAG_N = 3'h2;
    localparam logic [BIT_W-1:0] FLAG_V = 3'h3;
    localparam logic [BIT_W-1:0] FLAG_H = 3'h5;

    // Program counter steps, in words
    localparam logic [PC_W-1:0] PC_STEP_NEXT     = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_SKIP_ONE = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_SKIP_TWO = 16'h0003;

    // Execution lengths in clock cycles
    localparam logic [CNT_W-1:0] CYC_FALL     = 2'h1;
    localparam logic [CNT_W-1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [CNT_W-1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [CNT_W-1:0] CYC_BRANCH   = 2'h2;
    localparam logic [CNT_W-1:0] CNT_RST      = 2'h0;
    localparam logic [PC_W-1:0]  PC_RST       = 16'h0000;

    typedef enum logic [4:0] {
        skip_on_reg_bit_clear      = 5'h00,
        skip_on_reg_bit_set        = 5'h01,
        skip_on_io_bit_clear       = 5'h02,
        skip_on_io_bit_set         = 5'h03,
        branch_on_flag_set         = 5'h04,
        branch_on_flag_clear       = 5'h05,
        branch_if_equal            = 5'h06,
        branch_if_not_equal        = 5'h07,
        branch_if_carry_set        = 5'h08,
        branch_if_carry_clear      = 5'h09,
        branch_if_same_or_higher   = 5'h0a,
        branch_if_lower            = 5'h0b,
        branch_if_minus            = 5'h0c,
        branch_if_plus             = 5'h0d,
        branch_if_signed_ge        = 5'h0e,
        branch_if_signed_lt        = 5'h0f,
        branch_if_half_carry_set   = 5'h10,
        branch_if_half_carry_clear = 5'h11
    } op_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } state_type;

endpackage : cond_flow_pkg

// File: verilog/cond_eval.sv
// Condition evaluator: decides whether a skip or branch is taken.
// Assumes operands are stable in the cycle the operation is accepted.
`timescale 1ns/1ps
module cond_eval (
    input  wire cond_flow_pkg::op_type                   i_op,
    input  wire logic [cond_flow_pkg::BIT_W-1:0]         i_bit_sel,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]        i_reg_value,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]        i_io_value,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]        i_status_flags,
    output logic                                          o_taken,
    output logic                                          o_is_skip
);
    logic flag_c;
    logic flag_z;
    logic flag_n;
    logic flag_v;
    logic flag_h;

    assign flag_c = i_status_flags[cond_flow_pkg::FLAG_C];
    assign flag_z = i_status_flags[cond_flow_pkg::FLAG_Z];
    assign flag_n = i_status_flags[cond_flow_pkg::FLAG_N];
    assign flag_v = i_status_flags[cond_flow_pkg::FLAG_V];
    assign flag_h = i_status_flags[cond_flow_pkg::FLAG_H];

    always_comb begin
        o_is_skip = 1'b0;
        o_taken   = 1'b0;
        case (i_op)
            cond_flow_pkg::skip_on_reg_bit_clear: begin
                o_is_skip = 1'b1;
                o_taken   = ~i_reg_value[i_bit_sel]; // RULE_01
            end
            cond_flow_pkg::skip_on_reg_bit_set: begin
                o_is_skip = 1'b1;
                o_taken   = i_reg_value[i_bit_sel]; // RULE_02
            end
            cond_flow_pkg::skip_on_io_bit_clear: begin
                o_is_skip = 1'b1;
                o_taken   = ~i_io_value[i_bit_sel]; // RULE_03
            end
            cond_flow_pkg::skip_on_io_bit_set: begin
                o_is_skip = 1'b1;
                o_taken   = i_io_value[i_bit_sel]; // RULE_04
            end
            cond_flow_pkg::branch_on_flag_set:
                o_taken = i_status_flags[i_bit_sel]; // RULE_06
            cond_flow_pkg::branch_on_flag_clear:
                o_taken = ~i_status_flags[i_bit_sel]; // RULE_07
            cond_flow_pkg::branch_if_equal:            o_taken = flag_z; // RULE_08
            cond_flow_pkg::branch_if_not_equal:        o_taken = ~flag_z; // RULE_08
            cond_flow_pkg::branch_if_carry_set:        o_taken = flag_c; // RULE_09
            cond_flow_pkg::branch_if_carry_clear:      o_taken = ~flag_c; // RULE_09
            cond_flow_pkg::branch_if_same_or_higher:   o_taken = ~flag_c; // RULE_10
            cond_flow_pkg::branch_if_lower:            o_taken = flag_c; // RULE_10
            cond_flow_pkg::branch_if_minus:            o_taken = flag_n; // RULE_11
            cond_flow_pkg::branch_if_plus:             o_taken = ~flag_n; // RULE_11
            cond_flow_pkg::branch_if_signed_ge:        o_taken = ~(flag_n ^ flag_v); // RULE_12
            cond_flow_pkg::branch_if_signed_lt:        o_taken = flag_n ^ flag_v; // RULE_13
            cond_flow_pkg::branch_if_half_carry_set:   o_taken = flag_h; // RULE_14
            cond_flow_pkg::branch_if_half_carry_clear: o_taken = ~flag_h; // RULE_14
            default: begin
                o_is_skip = 1'b0;
                o_taken   = 1'b0;
            end
        endcase
    end

endmodule : cond_eval

// File: verilog/conditional_branch_skip_unit.sv
// Conditional skip and relative branch execution for an 8-bit core.
// Assumes decoder, register file, I/O space and flags share i_ref_clk.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Register bit clear skips next instruction
// RULE_02: Register bit set skips next instruction
// RULE_03: I/O bit clear skips next instruction
// RULE_04: I/O bit set skips next instruction
// RULE_05: Skips take one, two or three cycles
// RULE_06: Selected flag set branches to PC+k+1
// RULE_07: Selected flag clear branches to PC+k+1
// RULE_08: Equal/not-equal follow zero flag
// RULE_09: Carry set/clear follow carry flag
// RULE_10: Same-or-higher on C=0, lower on C=1
// RULE_11: Minus on N=1, plus on N=0
// RULE_12: Signed ge when N xor V is 0
// RULE_13: Signed lt when N xor V is 1
// RULE_14: Half-carry set/clear follow H flag
// RULE_15: Branch one cycle untaken, two taken
// RULE_16: Offset k is signed word offset
// RULE_17: Skip length and PC step match words
// RULE_18: Status flags are never written
module conditional_branch_skip_unit (
    input  wire logic                                   i_ref_clk,
    input  wire logic                                   i_sys_rst,
    input  wire logic                                   i_instr_valid,
    input  wire cond_flow_pkg::op_type                  i_op,
    input  wire logic [cond_flow_pkg::BIT_W-1:0]        i_bit_sel,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]       i_reg_value,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]       i_io_value,
    input  wire logic [cond_flow_pkg::DATA_W-1:0]       i_status_flags,
    input  wire logic [cond_flow_pkg::OFF_W-1:0]        i_offset,
    input  wire logic [cond_flow_pkg::PC_W-1:0]         i_pc,
    input  wire logic                                   i_next_two_word,
    output logic                                        o_busy,
    output logic                                        o_done,
    output logic                                        o_taken,
    output logic                                        o_pc_load,
    output logic [cond_flow_pkg::PC_W-1:0]              o_pc_value,
    output logic                                        o_flags_we
);
    cond_flow_pkg::state_type            state_q;
    cond_flow_pkg::state_type            state_d;
    logic [cond_flow_pkg::CNT_W-1:0]     cnt_q;
    logic [cond_flow_pkg::CNT_W-1:0]     cnt_d;
    logic [cond_flow_pkg::PC_W-1:0]      pc_q;
    logic [cond_flow_pkg::PC_W-1:0]      pc_d;
    logic                                taken_q;
    logic                                taken_d;
    logic                                done_q;
    logic                                done_d;
    logic                                busy_q;
    logic                                busy_d;
    logic                                flags_we_q;
    logic                                accept;
    logic                                cond_taken;
    logic                                cond_is_skip;
    logic [cond_flow_pkg::PC_W-1:0]      off_ext;
    logic [cond_flow_pkg::PC_W-1:0]      target;
    logic [cond_flow_pkg::CNT_W-1:0]     cycles;

    cond_eval u_cond_eval (
        .i_op           (i_op),
        .i_bit_sel      (i_bit_sel),
        .i_reg_value    (i_reg_value),
        .i_io_value     (i_io_value),
        .i_status_flags (i_status_flags),
        .o_taken        (cond_taken),
        .o_is_skip      (cond_is_skip)
    );

    // A new operation is only taken while idle; valid during busy is ignored
    assign accept  = i_instr_valid && (state_q == cond_flow_pkg::ST_IDLE);
    // Sign extension lets a branch reach back as well as forward
    assign off_ext = {{(cond_flow_pkg::PC_W-cond_flow_pkg::OFF_W)
                       {i_offset[cond_flow_pkg::OFF_W-1]}},
                      i_offset}; // RULE_16

    always_comb begin
        target = i_pc + cond_flow_pkg::PC_STEP_NEXT;
        cycles = cond_flow_pkg::CYC_FALL; // RULE_15
        if (cond_taken && cond_is_skip) begin
            if (i_next_two_word) begin
                target = i_pc + cond_flow_pkg::PC_STEP_SKIP_TWO; // RULE_17
                cycles = cond_flow_pkg::CYC_SKIP_TWO; // RULE_05
            end else begin
                target = i_pc + cond_flow_pkg::PC_STEP_SKIP_ONE; // RULE_17
                cycles = cond_flow_pkg::CYC_SKIP_ONE; // RULE_05
            end
        end else if (cond_taken) begin
            target = i_pc + off_ext + cond_flow_pkg::PC_STEP_NEXT; // RULE_06
            cycles = cond_flow_pkg::CYC_BRANCH; // RULE_15
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pc_d    = pc_q;
        taken_d = taken_q;
        done_d  = 1'b0;
        busy_d  = busy_q;
        case (state_q)
            cond_flow_pkg::ST_IDLE: begin
                if (accept) begin
                    pc_d    = target;
                    taken_d = cond_taken;
                    if (cycles == cond_flow_pkg::CYC_FALL) begin
                        done_d = 1'b1;
                    end else begin
                        state_d = cond_flow_pkg::ST_WAIT;
                        cnt_d   = cycles - cond_flow_pkg::CYC_FALL;
                        busy_d  = 1'b1;
                    end
                end
            end
            cond_flow_pkg::ST_WAIT: begin
                cnt_d = cnt_q - cond_flow_pkg::CYC_FALL;
                if (cnt_q == cond_flow_pkg::CYC_FALL) begin
                    state_d = cond_flow_pkg::ST_IDLE;
                    done_d  = 1'b1;
                    busy_d  = 1'b0;
                end
            end
            default: begin
                state_d = cond_flow_pkg::ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q    <= cond_flow_pkg::ST_IDLE;
            cnt_q      <= cond_flow_pkg::CNT_RST;
            pc_q       <= cond_flow_pkg::PC_RST;
            taken_q    <= 1'b0;
            done_q     <= 1'b0;
            busy_q     <= 1'b0;
            flags_we_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            pc_q       <= pc_d;
            taken_q    <= taken_d;
            done_q     <= done_d;
            busy_q     <= busy_d;
            flags_we_q <= 1'b0; // RULE_18
        end
    end

    assign o_busy     = busy_q;
    assign o_done     = done_q;
    assign o_pc_load  = done_q;
    assign o_taken    = taken_q;
    assign o_pc_value = pc_q;
    assign o_flags_we = flags_we_q;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_finish_taken;
        o_done && o_pc_load && o_taken;
    endsequence

    sequence s_finish_fall;
        o_done && o_pc_load && !o_taken;
    endsequence

    property p_reg_clr_skip_one;
        accept && i_op == cond_flow_pkg::skip_on_reg_bit_clear && !i_reg_value[i_bit_sel]
            && !i_next_two_word
        |-> ##1 (o_busy && !o_done) ##1 s_finish_taken
            ##0 (o_pc_value == $past(i_pc, 2) + cond_flow_pkg::PC_STEP_SKIP_ONE);
    endproperty
    a_reg_clr_skip_one: assert property (p_reg_clr_skip_one) // RULE_01
        else $error("reg clear skip bad");

    property p_reg_set_skip_two;
        accept && i_op == cond_flow_pkg::skip_on_reg_bit_set && i_reg_value[i_bit_sel]
            && i_next_two_word
        |-> ##1 (o_busy && !o_done) [*2] ##1 s_finish_taken
            ##0 (o_pc_value == $past(i_pc, 3) + cond_flow_pkg::PC_STEP_SKIP_TWO);
    endproperty
    a_reg_set_skip_two: assert property (p_reg_set_skip_two) // RULE_02
        else $error("reg set skip bad");

    property p_io_clr_fall;
        accept && i_op == cond_flow_pkg::skip_on_io_bit_clear && i_io_value[i_bit_sel]
        |-> ##1 s_finish_fall ##0 (o_pc_value == $past(i_pc) + cond_flow_pkg::PC_STEP_NEXT);
    endproperty
    a_io_clr_fall: assert property (p_io_clr_fall) else $error("io clear fall bad"); // RULE_03

    property p_io_set_skip;
        accept && i_op == cond_flow_pkg::skip_on_io_bit_set && i_io_value[i_bit_sel]
        |-> ##[2:3] s_finish_taken;
    endproperty
    a_io_set_skip: assert property (p_io_set_skip) else $error("io set skip bad"); // RULE_04

    property p_skip_length;
        accept && cond_is_skip |-> ##[1:3] o_done;
    endproperty
    a_skip_length: assert property (p_skip_length) else $error("skip length bad"); // RULE_05

    property p_branch_target;
        accept && !cond_is_skip && cond_taken
        |-> ##1 !o_done ##1 s_finish_taken
            ##0 (o_pc_value == $past(i_pc, 2) + $past(off_ext, 2) + cond_flow_pkg::PC_STEP_NEXT);
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("branch target bad"); // RULE_06

    property p_flag_clear;
        accept && i_op == cond_flow_pkg::branch_on_flag_clear && i_status_flags[i_bit_sel]
        |-> ##1 s_finish_fall;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear branch bad"); // RULE_07

    property p_signed_lt;
        accept && i_op == cond_flow_pkg::branch_if_signed_lt
            && (i_status_flags[cond_flow_pkg::FLAG_N] ^ i_status_flags[cond_flow_pkg::FLAG_V])
        |-> ##2 s_finish_taken;
    endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed lt bad"); // RULE_13

    property p_untaken_one_cycle;
        accept && !cond_taken |-> ##1 (s_finish_fall and !o_busy);
    endproperty
    a_untaken_one_cycle: assert property (p_untaken_one_cycle) // RULE_15
        else $error("untaken length bad");

    property p_flags_quiet;
        !o_flags_we;
    endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flags written"); // RULE_18

endmodule : conditional_branch_skip_unit

// File: bench/conditional_branch_skip_unit_test.sv
// Self-checking bench for the conditional skip and relative branch unit.
// Assumes one core clock; inputs move on falling edges and outputs are read there.
`timescale 1ns/1ps
module conditional_branch_skip_unit_test;
    logic                    ref_clk;
    logic                    sys_rst;
    logic                    instr_valid;
    cond_flow_pkg::op_type   op;
    logic [2:0]              bit_sel;
    logic [7:0]              reg_value;
    logic [7:0]              io_value;
    logic [7:0]              status_flags;
    logic [6:0]              offset;
    logic [15:0]             pc;
    logic                    next_two_word;
    logic                    busy;
    logic                    done;
    logic                    taken;
    logic                    pc_load;
    logic [15:0]             pc_value;
    logic                    flags_we;
    int                      errors;
    int                      compares;

    conditional_branch_skip_unit u_dut (
        .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_instr_valid(instr_valid), .i_op(op),
        .i_bit_sel(bit_sel), .i_reg_value(reg_value), .i_io_value(io_value),
        .i_status_flags(status_flags), .i_offset(offset), .i_pc(pc),
        .i_next_two_word(next_two_word), .o_busy(busy), .o_done(done), .o_taken(taken),
        .o_pc_load(pc_load), .o_pc_value(pc_value), .o_flags_we(flags_we)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    function automatic logic exp_take(cond_flow_pkg::op_type o, logic [2:0] b, logic [7:0] r,
                                      logic [7:0] io, logic [7:0] f);
        case (o)
            cond_flow_pkg::skip_on_reg_bit_clear:      return !r[b];
            cond_flow_pkg::skip_on_reg_bit_set:        return r[b];
            cond_flow_pkg::skip_on_io_bit_clear:       return !io[b];
            cond_flow_pkg::skip_on_io_bit_set:         return io[b];
            cond_flow_pkg::branch_on_flag_set:         return f[b];
            cond_flow_pkg::branch_on_flag_clear:       return !f[b];
            cond_flow_pkg::branch_if_equal:            return f[cond_flow_pkg::FLAG_Z];
            cond_flow_pkg::branch_if_not_equal:        return !f[cond_flow_pkg::FLAG_Z];
            cond_flow_pkg::branch_if_carry_set:        return f[cond_flow_pkg::FLAG_C];
            cond_flow_pkg::branch_if_carry_clear:      return !f[cond_flow_pkg::FLAG_C];
            cond_flow_pkg::branch_if_same_or_higher:   return !f[cond_flow_pkg::FLAG_C];
            cond_flow_pkg::branch_if_lower:            return f[cond_flow_pkg::FLAG_C];
            cond_flow_pkg::branch_if_minus:            return f[cond_flow_pkg::FLAG_N];
            cond_flow_pkg::branch_if_plus:             return !f[cond_flow_pkg::FLAG_N];
            cond_flow_pkg::branch_if_signed_ge:
                return !(f[cond_flow_pkg::FLAG_N] ^ f[cond_flow_pkg::FLAG_V]);
            cond_flow_pkg::branch_if_signed_lt:
                return f[cond_flow_pkg::FLAG_N] ^ f[cond_flow_pkg::FLAG_V];
            cond_flow_pkg::branch_if_half_carry_set:   return f[cond_flow_pkg::FLAG_H];
            default:                                   return !f[cond_flow_pkg::FLAG_H];
        endcase
    endfunction : exp_take

    task automatic set_in(cond_flow_pkg::op_type o, logic [2:0] b, logic [7:0] r, logic [7:0] io,
                          logic [7:0] f, logic [6:0] k, logic [15:0] p, logic two);
        instr_valid   = 1'b1;
        op            = o;
        bit_sel       = b;
        reg_value     = r;
        io_value      = io;
        status_flags  = f;
        offset        = k;
        pc            = p;
        next_two_word = two;
    endtask : set_in

    // Issues one operation, then judges its length, outcome and target
    task automatic run_op(cond_flow_pkg::op_type o, logic [2:0] b, logic [7:0] r, logic [7:0] io,
                          logic [7:0] f, logic [6:0] k, logic [15:0] p, logic two);
        logic        t;
        logic [15:0] n;
        logic [15:0] cnt;
        logic [15:0] epc;
        t = exp_take(o, b, r, io, f);
        if (!t) begin
            n   = 16'h0001;
            epc = p + 16'h0001;
        end else if (o <= cond_flow_pkg::skip_on_io_bit_set) begin
            n   = two ? 16'h0003 : 16'h0002;
            epc = p + n;
        end else begin
            n   = 16'h0002;
            epc = p + {{9{k[6]}}, k} + 16'h0001;
        end
        @(negedge ref_clk);
        set_in(o, b, r, io, f, k, p, two);
        @(negedge ref_clk);
        instr_valid = 1'b0;
        cnt = 16'h0001;
        while (done !== 1'b1 && cnt < 16'h0006) begin
            check("busy while waiting", busy, 16'h0001);
            @(negedge ref_clk);
            cnt++;
        end
        check("cycle count", cnt, n);
        check("taken", taken, t);
        check("pc value", pc_value, epc);
        check("pc load", pc_load, 16'h0001);
        check("busy at done", busy, 16'h0000);
        check("flags write", flags_we, 16'h0000);
    endtask : run_op

    // Other bits and the unused source hold the opposite value, so a wrong pick shows
    task automatic test_skips();
        logic [7:0] v;
        for (int i = 0; i < 16; i++) begin
            v = (8'h01 << (i[2:0] + 3'h3)) ^ {8{!i[1]}};
            run_op(cond_flow_pkg::op_type'(i[3:2]), i[2:0] + 3'h3, i[3] ? ~v : v, i[3] ? v : ~v,
                   8'h00, 7'h00, 16'h2000 + i[15:0], i[0]);
        end
    endtask : test_skips

    task automatic test_flag_branch();
        for (int i = 0; i < 32; i++)
            run_op(i[4] ? cond_flow_pkg::branch_on_flag_clear : cond_flow_pkg::branch_on_flag_set,
                   i[2:0], 8'h00, 8'h00, i[3] ? (8'h01 << i[2:0]) : ~(8'h01 << i[2:0]),
                   7'h05, 16'h0300, 1'b0);
    endtask : test_flag_branch

    task automatic test_named_branches();
        logic [7:0] pat [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h20};
        for (int i = 6; i < 18; i++)
            for (int j = 0; j < 7; j++)
                run_op(cond_flow_pkg::op_type'(i[4:0]), 3'h0, 8'h00, 8'h00, pat[j],
                       7'h12, 16'h0400, 1'b1);
    endtask : test_named_branches

    task automatic test_offsets();
        run_op(cond_flow_pkg::branch_if_equal, 3'h0, 8'h00, 8'h00, 8'h02, 7'h40, 16'h0010, 1'b0);
        run_op(cond_flow_pkg::branch_if_equal, 3'h0, 8'h00, 8'h00, 8'h02, 7'h3f, 16'hffd0, 1'b0);
        run_op(cond_flow_pkg::branch_if_equal, 3'h0, 8'h00, 8'h00, 8'h02, 7'h7f, 16'h0800, 1'b0);
    endtask : test_offsets

    // A request held during busy is ignored, then accepted in the done cycle
    task automatic test_refused();
        @(negedge ref_clk);
        set_in(cond_flow_pkg::branch_if_carry_set, 3'h0, 8'h00, 8'h00, 8'h01, 7'h05, 16'h0100,
               1'b0);
        @(negedge ref_clk);
        set_in(cond_flow_pkg::branch_if_minus, 3'h0, 8'h00, 8'h00, 8'h00, 7'h09, 16'h0500, 1'b0);
        check("busy", busy, 16'h0001);
        check("early done", done, 16'h0000);
        @(negedge ref_clk);
        check("first done", done, 16'h0001);
        check("first pc", pc_value, 16'h0106);
        @(negedge ref_clk);
        instr_valid = 1'b0;
        check("second done", done, 16'h0001);
        check("second taken", taken, 16'h0000);
        check("second pc", pc_value, 16'h0501);
    endtask : test_refused

    task automatic test_reset();
        @(negedge ref_clk);
        set_in(cond_flow_pkg::skip_on_reg_bit_set, 3'h7, 8'h80, 8'h00, 8'h00, 7'h00, 16'h0700,
               1'b1);
        @(negedge ref_clk);
        instr_valid = 1'b0;
        sys_rst     = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        check("reset busy", busy, 16'h0000);
        check("reset done", done, 16'h0000);
        check("reset taken", taken, 16'h0000);
        check("reset pc", pc_value, 16'h0000);
        run_op(cond_flow_pkg::skip_on_io_bit_clear, 3'h6, 8'h00, 8'h00, 8'h00, 7'h00,
               16'h0900, 1'b0);
    endtask : test_reset

    initial begin
        errors   = 0;
        compares = 0;
        sys_rst  = 1'b1;
        set_in(cond_flow_pkg::branch_if_equal, 3'h0, 8'h00, 8'h00, 8'h00, 7'h00, 16'h0000, 1'b0);
        instr_valid = 1'b0;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        test_skips();
        test_flag_branch();
        test_named_branches();
        test_offsets();
        test_refused();
        test_reset();
        final_report();
    end

    // Roughly 140 operations of at most four cycles each fit well inside this span
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        final_report();
    end
endmodule : conditional_branch_skip_unit_test
